/* cdhap_pkg.sv */
package cdhap_pkg;

    // Widths and counts
    localparam int unsigned CDHAP_PAR_W = 6;
    localparam int unsigned CDHAP_SAMPLE_W = 16;
    localparam int unsigned CDHAP_NUM_VOL = 19;
    localparam int unsigned CDHAP_FIFO_DEPTH = 4;

    // Volume word fields
    localparam int unsigned CDHAP_MUTE_POS = 5;
    localparam int unsigned CDHAP_GAIN_W = 5;
    localparam logic [5:0] CDHAP_VOL_RESET = 6'h20;
    localparam logic [4:0] CDHAP_ADDR_MAX = 5'h12;

    // Serial timing: bit clock is the master clock divided by eight
    localparam int unsigned CDHAP_BCLK_DIV = 8;
    localparam int unsigned CDHAP_BCLK_HALF = CDHAP_BCLK_DIV / 2;
    localparam int unsigned CDHAP_BITS_PER_HALF = 16;
    localparam logic [2:0] CDHAP_DIV_RESET = 3'h0;
    localparam logic [3:0] CDHAP_BIT_RESET = 4'h0;
    // Pin filter after reset: host strobes idle high, data, serial and test pins low
    localparam logic [12:0] CDHAP_PIN_RESET = 13'h1e00;

    typedef struct packed {
        logic mute_bit;
        logic [CDHAP_GAIN_W-1:0] gain_code;
    } cdhap_vol_s;

    typedef struct packed {
        logic [CDHAP_SAMPLE_W-1:0] left;
        logic [CDHAP_SAMPLE_W-1:0] right;
    } cdhap_frame_s;

endpackage : cdhap_pkg

/* cdhap_fifo.sv */
module cdhap_fifo
    import cdhap_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic [WIDTH-1:0] out_data, next_out_data;
    logic out_valid, next_out_valid;
    logic push, pop;

    // Read data sits in a register; one word is held in it besides the array
    always_comb begin
        pop = (count != '0) && (!out_valid || i_out_ready);
        push = i_in_valid && (count != (AW+1)'(DEPTH));
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_out_data = pop ? mem[rd_ptr] : out_data;
        next_out_valid = pop ? 1'b1 : (i_out_ready ? 1'b0 : out_valid);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = out_valid;
    assign o_out_data = out_data;

endmodule : cdhap_fifo

/* cdhap_top.sv */
// Summary of operation
// - Transceiver direction high while data pins are inputs, low while driving.
// - Transceiver enable low whenever data input on the pins is enabled.
// - Chip select active low; when high, pins float and strobes are ignored.
// - Register select low picks address register, high picks addressed data register.
// - Device stays powered down while reset is held low.
// - Frame clock low during left channel, high during right channel.
// - Bit clock is the master clock divided by eight.
// - Serial input bits follow the bit clock, two's complement, MSB first.
// - Serial output shifts samples with the bit clock, two's complement, MSB first.
// - Each channel sample is 16 bits wide.
// - Parallel port carries 6-bit addresses and volume settings on one set of pins.
// - Each volume offers 0 to -46.5 dB in 1.5 dB steps plus mute.
// - Top bit forces mute; else low five bits give 1.5 dB times n attenuation.
// - After reset every volume register is mute.
// - Address register selects one of nineteen volume registers, 0 through 18.
module cdhap_top
    import cdhap_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Parallel host port
    input wire logic i_chip_select_n,
    input wire logic i_write_strobe_n,
    input wire logic i_read_strobe_n,
    input wire logic i_reg_select,
    input wire logic [CDHAP_PAR_W-1:0] i_parallel_data_bus,
    output logic [CDHAP_PAR_W-1:0] o_parallel_data_bus,
    output logic o_parallel_data_bus_oe,
    output logic o_xcvr_dir_out,
    output logic o_xcvr_enable_n,
    // Test and power
    input wire logic i_test_mode_a,
    input wire logic i_test_mode_b,
    output logic o_power_down,
    output logic o_test_mode,
    // Volume settings to the analog mixers
    output logic [CDHAP_NUM_VOL*CDHAP_PAR_W-1:0] o_volume,
    // Serial audio port
    output logic o_bclk,
    output logic o_lrclk,
    input wire logic i_serial_in,
    output logic o_serial_out,
    // Converter sample streams
    output logic o_rx_valid,
    output cdhap_frame_s o_rx_frame,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire cdhap_frame_s i_tx_frame
);

    // Pin synchronisers: stage 1 feeds only stage 2; changes count when 2 and 3 agree
    localparam int unsigned NSYNC = 4 + CDHAP_PAR_W + 1 + 2;
    logic [NSYNC-1:0] pin_raw, sync1, sync2, sync3, pin_stable;
    assign pin_raw = {i_chip_select_n, i_write_strobe_n, i_read_strobe_n, i_reg_select,
                      i_parallel_data_bus, i_serial_in, i_test_mode_a, i_test_mode_b};

    always_ff @(posedge i_core_clk) begin
        sync1 <= pin_raw;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    logic [NSYNC-1:0] next_pin_stable;
    always_comb begin
        for (int i = 0; i < NSYNC; i++) begin
            next_pin_stable[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_stable[i];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pin_stable <= CDHAP_PIN_RESET;
        end else begin
            pin_stable <= next_pin_stable;
        end
    end

    logic cs_n, wr_n, rd_n, sel, ser_in;
    logic tma, tmb;
    logic [CDHAP_PAR_W-1:0] pdata;
    assign {cs_n, wr_n, rd_n, sel, pdata, ser_in, tma, tmb} = pin_stable;

    // Host port state
    logic [CDHAP_PAR_W-1:0] vol [CDHAP_NUM_VOL];
    logic [CDHAP_PAR_W-1:0] next_vol [CDHAP_NUM_VOL];
    logic [CDHAP_PAR_W-1:0] addr, next_addr;
    logic wr_d, next_wr_d;
    logic [CDHAP_PAR_W-1:0] pout, next_pout;
    logic poe, next_poe;
    logic dir, next_dir, en_n, next_en_n;
    logic wr_fall;

    always_comb begin
        next_wr_d = wr_n;
        // Strobes count only while selected; write on falling edge
        wr_fall = !cs_n && wr_d && !wr_n;
        next_addr = addr;
        for (int i = 0; i < CDHAP_NUM_VOL; i++) begin
            next_vol[i] = vol[i];
        end
        if (wr_fall) begin
            if (!sel) begin
                next_addr = pdata;
            end else if (addr <= CDHAP_PAR_W'(CDHAP_ADDR_MAX)) begin
                // Writes to unmapped addresses are dropped
                next_vol[addr[4:0]] = pdata;
            end
        end
        // Drive pins only on a selected data read; avoid contention on address reads
        next_poe = !cs_n && !rd_n && wr_n && sel;
        next_pout = (addr <= CDHAP_PAR_W'(CDHAP_ADDR_MAX)) ? vol[addr[4:0]] : '0;
        next_dir = !next_poe;
        next_en_n = !(!cs_n && !next_poe);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            addr <= '0;
            wr_d <= 1'b1;
            pout <= '0;
            poe <= 1'b0;
            dir <= 1'b1;
            en_n <= 1'b1;
            for (int i = 0; i < CDHAP_NUM_VOL; i++) begin
                vol[i] <= CDHAP_VOL_RESET;
            end
        end else begin
            addr <= next_addr;
            wr_d <= next_wr_d;
            pout <= next_pout;
            poe <= next_poe;
            dir <= next_dir;
            en_n <= next_en_n;
            for (int i = 0; i < CDHAP_NUM_VOL; i++) begin
                vol[i] <= next_vol[i];
            end
        end
    end

    // Volume outputs: a set top bit overrides any gain code
    logic [CDHAP_NUM_VOL*CDHAP_PAR_W-1:0] vol_out, next_vol_out;
    always_comb begin
        for (int i = 0; i < CDHAP_NUM_VOL; i++) begin
            next_vol_out[i*CDHAP_PAR_W +: CDHAP_PAR_W] =
                next_vol[i][CDHAP_MUTE_POS] ? CDHAP_VOL_RESET : next_vol[i];
        end
    end

    // Power-down and test mode flags
    logic pd, next_pd, tm, next_tm;
    always_comb begin
        next_pd = 1'b0;
        // Test pins share the host pin synchroniser
        next_tm = tma || tmb;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            vol_out <= {CDHAP_NUM_VOL{CDHAP_VOL_RESET}};
            pd <= 1'b1;
            tm <= 1'b0;
        end else begin
            vol_out <= next_vol_out;
            pd <= next_pd;
            tm <= next_tm;
        end
    end

    // Serial audio timing
    logic [2:0] div, next_div;
    logic [3:0] bitn, next_bitn;
    logic bclk, next_bclk, lr, next_lr;
    logic bclk_fall, bclk_rise;
    // Input sampled late in the bit: the pin synchroniser costs four clocks
    logic rx_take;
    logic [CDHAP_SAMPLE_W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
    logic [CDHAP_SAMPLE_W-1:0] rx_left, next_rx_left;
    cdhap_frame_s tx_hold, next_tx_hold, rx_frame, next_rx_frame;
    logic rx_valid, next_rx_valid, so, next_so;
    logic fifo_out_valid, fifo_pop;
    cdhap_frame_s fifo_out;

    cdhap_fifo #(
        .WIDTH(2 * CDHAP_SAMPLE_W),
        .DEPTH(CDHAP_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_in_valid(i_tx_valid),
        .o_in_ready(),
        .i_in_data(i_tx_frame),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out)
    );

    // Ready mirrored through a flop: the FIFO accepts only while not full
    logic tx_ready, next_tx_ready;
    logic [2:0] fill, next_fill;

    always_comb begin
        next_div = div + 3'h1;
        bclk_rise = (div == 3'(CDHAP_BCLK_HALF - 1));
        bclk_fall = (div == 3'(CDHAP_BCLK_DIV - 1));
        rx_take = (div == 3'(CDHAP_BCLK_DIV - 2));
        next_bclk = bclk_rise ? 1'b1 : (bclk_fall ? 1'b0 : bclk);
        next_bitn = bitn;
        next_lr = lr;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_rx_left = rx_left;
        next_tx_hold = tx_hold;
        next_rx_frame = rx_frame;
        next_rx_valid = 1'b0;
        next_so = so;
        fifo_pop = 1'b0;
        if (rx_take) begin
            next_rx_sh = {rx_sh[CDHAP_SAMPLE_W-2:0], ser_in};
        end
        if (bclk_fall) begin
            next_bitn = bitn + 4'h1;
            if (bitn == 4'(CDHAP_BITS_PER_HALF - 1)) begin
                next_lr = !lr;
                if (!lr) begin
                    next_rx_left = rx_sh;
                    next_tx_sh = tx_hold.right;
                end else begin
                    next_rx_frame = '{left: rx_left, right: rx_sh};
                    next_rx_valid = 1'b1;
                    // Underrun repeats silence rather than stalling the frame clock
                    fifo_pop = fifo_out_valid;
                    next_tx_hold = fifo_out_valid ? fifo_out : '0;
                    next_tx_sh = fifo_out_valid ? fifo_out.left : '0;
                end
                next_so = next_tx_sh[CDHAP_SAMPLE_W-1];
                next_tx_sh = {next_tx_sh[CDHAP_SAMPLE_W-2:0], 1'b0};
            end else begin
                next_so = tx_sh[CDHAP_SAMPLE_W-1];
                next_tx_sh = {tx_sh[CDHAP_SAMPLE_W-2:0], 1'b0};
            end
        end
        next_fill = fill + 3'(i_tx_valid && tx_ready) - 3'(fifo_pop);
        next_tx_ready = (next_fill < 3'(CDHAP_FIFO_DEPTH + 1));
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            div <= CDHAP_DIV_RESET;
            bitn <= CDHAP_BIT_RESET;
            bclk <= 1'b0;
            lr <= 1'b0;
            tx_sh <= '0;
            rx_sh <= '0;
            rx_left <= '0;
            tx_hold <= '0;
            rx_frame <= '0;
            rx_valid <= 1'b0;
            so <= 1'b0;
            fill <= 3'h0;
            tx_ready <= 1'b1;
        end else begin
            div <= next_div;
            bitn <= next_bitn;
            bclk <= next_bclk;
            lr <= next_lr;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            rx_left <= next_rx_left;
            tx_hold <= next_tx_hold;
            rx_frame <= next_rx_frame;
            rx_valid <= next_rx_valid;
            so <= next_so;
            fill <= next_fill;
            tx_ready <= next_tx_ready;
        end
    end

    assign o_parallel_data_bus = pout;
    assign o_parallel_data_bus_oe = poe;
    assign o_xcvr_dir_out = dir;
    assign o_xcvr_enable_n = en_n;
    assign o_power_down = pd;
    assign o_test_mode = tm;
    assign o_volume = vol_out;
    assign o_bclk = bclk;
    assign o_lrclk = lr;
    assign o_serial_out = so;
    assign o_rx_valid = rx_valid;
    assign o_rx_frame = rx_frame;
    assign o_tx_ready = tx_ready;

endmodule : cdhap_top

/* cdhap_checker.sv */
module cdhap_checker
    import cdhap_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_chip_select_n,
    input wire logic o_parallel_data_bus_oe,
    input wire logic o_xcvr_dir_out,
    input wire logic o_xcvr_enable_n,
    input wire logic o_power_down,
    input wire logic [CDHAP_NUM_VOL*CDHAP_PAR_W-1:0] o_volume,
    input wire logic o_bclk,
    input wire logic o_lrclk,
    input wire logic o_serial_out,
    input wire logic o_rx_valid
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // Cycles since the last frame clock edge; first edge after reset is not timed
    logic lr_prev;
    logic lr_seen;
    logic [7:0] lr_cnt;
    logic next_lr_seen;
    logic [7:0] next_lr_cnt;
    always_comb begin
        next_lr_cnt = (o_lrclk != lr_prev) ? 8'h00 : lr_cnt + 8'h01;
        next_lr_seen = lr_seen | (o_lrclk != lr_prev);
    end
    always_ff @(posedge i_core_clk) begin
        lr_prev <= i_nrst ? o_lrclk : 1'b0;
        lr_cnt <= i_nrst ? next_lr_cnt : 8'h00;
        lr_seen <= i_nrst ? next_lr_seen : 1'b0;
    end

    AST_DIR: assert property (o_xcvr_dir_out != o_parallel_data_bus_oe)
        else $error("direction not inverse of drive enable");
    AST_ENA: assert property (o_parallel_data_bus_oe |-> o_xcvr_enable_n)
        else $error("transceiver enabled while driving");
    AST_CS_IDLE: assert property (i_chip_select_n [*6] |-> !o_parallel_data_bus_oe && o_xcvr_enable_n)
        else $error("pins driven while deselected");
    AST_PWR_DN: assert property (disable iff (1'b0) !i_nrst |=> o_power_down)
        else $error("power down missing in reset");
    AST_VOL_RST: assert property (disable iff (1'b0) !i_nrst |=> o_volume == {CDHAP_NUM_VOL{CDHAP_VOL_RESET}})
        else $error("volumes not mute after reset");
    AST_BCLK: assert property ($rose(o_bclk) |-> o_bclk [*4] ##1 !o_bclk [*4] ##1 o_bclk)
        else $error("bit clock not divide by eight");
    AST_LR_EDGE: assert property ($changed(o_lrclk) |-> $fell(o_bclk))
        else $error("frame clock moved off bit clock fall");
    AST_LR_HALF: assert property ((o_lrclk != lr_prev) && lr_seen |-> lr_cnt == 8'h7f)
        else $error("frame half not 16 bit clocks");
    AST_SO_EDGE: assert property ($changed(o_serial_out) |-> $fell(o_bclk))
        else $error("serial out moved off bit clock fall");

    COV_RX: cover property (o_rx_valid);
    COV_RD: cover property ($rose(o_parallel_data_bus_oe));
    COV_FRAME: cover property ($fell(o_lrclk));
endmodule : cdhap_checker

bind cdhap_top cdhap_checker u_cdhap_checker (.i_core_clk, .i_nrst, .i_chip_select_n,
    .o_parallel_data_bus_oe, .o_xcvr_dir_out, .o_xcvr_enable_n, .o_power_down, .o_volume,
    .o_bclk, .o_lrclk, .o_serial_out, .o_rx_valid);

/* cdhap_dsp_model.sv */
module cdhap_dsp_model
    import cdhap_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_bclk,
    input wire logic i_lrclk,
    input wire logic i_so,
    input wire cdhap_frame_s i_frame,
    output logic o_si = 1'b0,
    output logic o_cap_valid = 1'b0,
    output cdhap_frame_s o_cap = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic b_q = 1'b0;
    logic l_q = 1'b0;
    logic [31:0] tx_sh = '0;
    logic [31:0] rx_sh = '0;
    // Frame starts at the frame clock fall: left word first, MSB first
    always @(posedge i_core_clk) begin
        b_q <= i_bclk;
        l_q <= i_lrclk;
        o_cap_valid <= 1'b0;
        if (i_bclk && !b_q) begin
            rx_sh <= {rx_sh[30:0], i_so};
        end
        if (!i_lrclk && l_q) begin
            o_cap <= rx_sh;
            o_cap_valid <= 1'b1;
            o_si <= i_frame[31];
            tx_sh <= {i_frame[30:0], 1'b0};
        end else if (!i_bclk && b_q) begin
            o_si <= tx_sh[31];
            tx_sh <= {tx_sh[30:0], 1'b0};
        end
    end
endmodule : cdhap_dsp_model

/* codec_digital_host_and_audio_port_bench.sv */
module codec_digital_host_and_audio_port_bench
    import cdhap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, sel = 1'b0;
    logic tma = 1'b0, tmb = 1'b0, tx_valid = 1'b0;
    logic [5:0] din = 6'h00;
    logic [5:0] dout;
    logic oe, dir, en_n, pdn, tm, bclk, lrclk, si, so, rx_valid, tx_ready, cap_valid;
    logic [CDHAP_NUM_VOL*CDHAP_PAR_W-1:0] vol;
    cdhap_frame_s tx_frame = '0, rx_src = '0, rx_frame, cap;
    cdhap_frame_s sent[$], got[$];
    logic [5:0] expv [19];
    logic [31:0] seed = 32'haa51787e;
    int n_mismatch = 0, n_checks = 0, cycles = 0;

    always #10 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic vchk();
        for (int i = 0; i < 19; i++) chk("volume", vol[6*i +: 6], expv[i]);
    endtask : vchk

    task automatic do_reset();
        expv = '{default: CDHAP_VOL_RESET};
        nrst <= 1'b0;
        // One eighth of a 256-clock sample period
        repeat (32) @(posedge clk);
        @(negedge clk);
        chk("power_down", pdn, 1);
        vchk();
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        chk("power_down", pdn, 0);
    endtask : do_reset

    // Strobes are held for four clocks so the pin synchronisers see every level
    task automatic hwr(logic c, logic s, logic [5:0] d);
        @(posedge clk);
        cs_n <= c;
        sel <= s;
        din <= d;
        repeat (4) @(posedge clk);
        wr_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("enable_n", en_n, c);
        wr_n <= 1'b1;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : hwr

    task automatic hrd(output logic [5:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        sel <= 1'b1;
        rd_n <= 1'b0;
        for (int k = 0; k < 12 && oe !== 1'b1; k++) @(negedge clk);
        chk("oe", oe, 1);
        chk("dir", dir, 0);
        chk("enable_n", en_n, 1);
        d = dout;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (7) @(negedge clk);
        chk("oe", oe, 0);
        chk("dir", dir, 1);
    endtask : hrd

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cap_valid === 1'b1 && cap != 0) got.push_back(cap);
        if (cycles == 40000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        logic [5:0] v, r;
        cdhap_frame_s f;
        logic full;
        full = 1'b0;
        @(posedge clk);
        do_reset();
        for (int i = 3; i >= 0; i--) begin
            @(posedge clk);
            {tmb, tma} <= 2'(i);
            repeat (8) @(negedge clk);
            chk("test_mode", tm, i != 0);
        end
        for (int a = 0; a < 20; a++) begin
            v = (a == 0) ? 6'h1f : (a == 18) ? 6'h00 : 6'(rnd());
            hwr(1'b0, 1'b0, 6'(a));
            hwr(1'b0, 1'b1, v);
            if (a < 19) expv[a] = v[5] ? CDHAP_VOL_RESET : v;
            vchk();
            hrd(r);
            chk("read", r, a < 19 ? v : 6'h00);
        end
        hwr(1'b0, 1'b0, 6'h03);
        hwr(1'b1, 1'b1, 6'h0a);
        hwr(1'b1, 1'b0, 6'h05);
        hwr(1'b0, 1'b1, 6'h07);
        expv[3] = 6'h07;
        vchk();
        for (int i = 0; i < 3; i++) begin
            rx_src <= (i == 0) ? 32'h80007fff : rnd();
            repeat (3) @(posedge rx_valid);
            @(negedge clk);
            chk("rx_frame", rx_frame, rx_src);
            @(posedge clk);
        end
        for (int i = 0; i < 7; i++) begin
            f = rnd() | 32'h00010001;
            tx_frame <= f;
            tx_valid <= 1'b1;
            @(posedge clk);
            while (tx_ready !== 1'b1) begin
                full = 1'b1;
                @(posedge clk);
            end
            sent.push_back(f);
        end
        tx_valid <= 1'b0;
        chk("tx_full", full, 1);
        for (int k = 0; k < 6000 && got.size() < 7; k++) @(posedge clk);
        for (int i = 0; i < 7; i++) chk("tx_frame", got[i], sent[i]);
        chk("tx_ready", tx_ready, 1);
        @(posedge clk);
        do_reset();
        close_out();
    end

    cdhap_top u_cdhap_top (
        .i_core_clk(clk), .i_nrst(nrst), .i_chip_select_n(cs_n), .i_write_strobe_n(wr_n),
        .i_read_strobe_n(rd_n), .i_reg_select(sel), .i_parallel_data_bus(din),
        .o_parallel_data_bus(dout), .o_parallel_data_bus_oe(oe), .o_xcvr_dir_out(dir),
        .o_xcvr_enable_n(en_n), .i_test_mode_a(tma), .i_test_mode_b(tmb), .o_power_down(pdn),
        .o_test_mode(tm), .o_volume(vol), .o_bclk(bclk), .o_lrclk(lrclk), .i_serial_in(si),
        .o_serial_out(so), .o_rx_valid(rx_valid), .o_rx_frame(rx_frame),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_frame(tx_frame)
    );

    cdhap_dsp_model u_cdhap_dsp_model (
        .i_core_clk(clk), .i_bclk(bclk), .i_lrclk(lrclk), .i_so(so), .i_frame(rx_src),
        .o_si(si), .o_cap_valid(cap_valid), .o_cap(cap)
    );
endmodule : codec_digital_host_and_audio_port_bench
